/* vlsl_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "vlsl_cfg.svh"

// How it works
// - Address is index plus base, or zero
// - Quad load: align, write all lanes
// - Last variants act alike, pass hint
// - Left load: shift in, zero right lanes
// - Right load: fetch below address, zero left
// - Right load aligned: all zeros, no fetch
// - Left control: bytes count to count+15
// - Right control: bytes 16-count to 31-count
// - Byte store: write one addressed lane
// - Halfword store: clear bit 63, two lanes
// - Word store: clear bits 62-63, four lanes
// - Left store: write leftmost 16-offset lanes
// - Right store: rightmost offset lanes below address
// - Right store aligned: no memory write
// - Quad store: align, write all lanes
// - Element load into addressed lane

module vlsl_top
  import vlsl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire vlsl_op_type req_op,
  input wire logic req_last_hint,
  input wire logic req_base_is_zero,
  input wire logic [63:0] req_base_gpr,
  input wire logic [63:0] req_index_gpr,
  input wire logic [127:0] req_source_vreg,
  input wire logic [4:0] req_dest_vreg,
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic mem_req_write,
  output logic [63:0] mem_req_addr,
  output logic [15:0] mem_req_byte_en,
  output logic [127:0] mem_req_wdata,
  output logic mem_req_last_hint,
  input wire logic mem_rsp_valid,
  input wire logic [127:0] mem_rsp_rdata,
  output logic done_valid,
  output logic done_is_load,
  output logic done_mem_skipped,
  output logic [4:0] done_dest_vreg,
  output logic [127:0] done_data
);

  // ----------------------------------------
  // State and held request
  // ----------------------------------------
  vlsl_state_type state_reg;
  vlsl_state_type state_next;
  vlsl_op_type op_reg;
  logic [63:0] ea_reg;
  logic [127:0] src_reg;
  logic [4:0] dest_reg;
  logic hint_reg;
  logic is_load_reg;
  logic skipped_reg;
  logic skipped_next;
  logic write_reg;
  logic [63:0] addr_reg;
  logic [15:0] be_reg;
  logic [127:0] wdata_reg;
  logic [127:0] data_reg;
  logic [127:0] data_next;

  // ----------------------------------------
  // Effective address
  // ----------------------------------------
  wire [63:0] base_term = req_base_is_zero ? `VLSL_ZERO_EA : req_base_gpr;
  wire [63:0] ea_sum = base_term + req_index_gpr;
  wire accept = req_valid && req_ready;

  // ----------------------------------------
  // Operation decoding
  // ----------------------------------------
  // Most kinds come as a load form and a store form
  function automatic logic op_pair(input vlsl_op_type op, input vlsl_op_type form_a, input vlsl_op_type form_b);
    return (op == form_a) || (op == form_b);
  endfunction

  // Bit 63 is the least significant address bit, so bits 60-63 are ea[3:0]
  function automatic logic [63:0] align_for(input vlsl_op_type op);
    logic [63:0] mask;
    case (op)
      OP_LOAD_QUAD, OP_STORE_QUAD:
      begin
        mask = `VLSL_ALIGN_QW;
      end
      OP_LOAD_ELEM_WORD, OP_STORE_ELEM_WORD:
      begin
        mask = `VLSL_ALIGN_WD;
      end
      OP_LOAD_ELEM_HALF, OP_STORE_ELEM_HALF:
      begin
        mask = `VLSL_ALIGN_HW;
      end
      default:
      begin
        mask = `VLSL_ALIGN_BYTE;
      end
    endcase
    return mask;
  endfunction

  wire op_is_store = op_reg[3];
  wire op_is_ctl = op_pair(op_reg, OP_MAKE_LEFT_SHIFT_CONTROL, OP_MAKE_RIGHT_SHIFT_CONTROL);
  wire op_is_right = op_pair(op_reg, OP_LOAD_RIGHT, OP_STORE_RIGHT);
  wire [63:0] align_mask = align_for(op_reg);
  wire [63:0] ea_eff = ea_reg & align_mask;
  wire [3:0] lane_offset = ea_eff[3:0];

  // Aligned right forms never touch memory
  wire right_aligned = op_is_right && (lane_offset == `VLSL_ZERO_OFF);
  wire needs_mem = !op_is_ctl && !right_aligned;

  // Memory always sees the containing quadword; right forms reach back to ea minus offset
  wire [63:0] quad_addr = ea_eff & `VLSL_ALIGN_QW;

  // ----------------------------------------
  // Lane steering
  // ----------------------------------------
  vlsl_steer_if steer_bus ();

  assign steer_bus.op = op_reg;
  assign steer_bus.lane_offset = lane_offset;
  assign steer_bus.source_vreg = src_reg;
  assign steer_bus.mem_rdata = mem_rsp_rdata;

  vlsl_lane_steer u_steer (
    .st(steer_bus.steer)
  );

  // ----------------------------------------
  // State decoding
  // ----------------------------------------
  wire in_idle = (state_reg == ST_IDLE);
  wire in_prep = (state_reg == ST_PREP);
  wire in_issue = (state_reg == ST_ISSUE);
  wire in_done = (state_reg == ST_DONE);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // One operation in flight; the core waits on req_ready instead of a queue
  always_comb
  begin
    state_next = state_reg;
    data_next = data_reg;
    skipped_next = skipped_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (accept)
        begin
          state_next = ST_PREP;
        end
      end
      ST_PREP:
      begin
        skipped_next = !needs_mem;
        if (needs_mem)
        begin
          state_next = ST_ISSUE;
        end
        else
        begin
          // Control vectors and aligned right loads and stores finish without memory
          data_next = op_is_store ? `VLSL_ZERO_QW : steer_bus.load_data;
          state_next = ST_DONE;
        end
      end
      ST_ISSUE:
      begin
        if (mem_req_ready)
        begin
          state_next = write_reg ? ST_DONE : ST_WAIT;
          if (write_reg)
          begin
            data_next = `VLSL_ZERO_QW;
          end
        end
      end
      ST_WAIT:
      begin
        if (mem_rsp_valid)
        begin
          data_next = steer_bus.load_data;
          state_next = ST_DONE;
        end
      end
      ST_DONE:
      begin
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Request capture
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_reg <= OP_LOAD_QUAD;
      ea_reg <= `VLSL_ZERO_EA;
      src_reg <= `VLSL_ZERO_QW;
      dest_reg <= 5'h00;
      hint_reg <= 1'b0;
      is_load_reg <= 1'b1;
    end
    else if (accept)
    begin
      op_reg <= req_op;
      ea_reg <= ea_sum;
      src_reg <= req_source_vreg;
      dest_reg <= req_dest_vreg;
      hint_reg <= req_last_hint;
      is_load_reg <= !req_op[3];
    end
  end

  // ----------------------------------------
  // Memory request fields
  // ----------------------------------------
  // Fields settle in the prepare cycle so the memory port sees only flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_reg <= 1'b0;
      addr_reg <= `VLSL_ZERO_EA;
      be_reg <= `VLSL_NO_LANES;
      wdata_reg <= `VLSL_ZERO_QW;
    end
    else if (in_prep)
    begin
      write_reg <= op_is_store;
      addr_reg <= quad_addr;
      be_reg <= op_is_store ? steer_bus.byte_en : `VLSL_ALL_LANES;
      wdata_reg <= op_is_store ? steer_bus.store_data : `VLSL_ZERO_QW;
    end
  end

  // ----------------------------------------
  // Completion data
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_reg <= `VLSL_ZERO_QW;
      skipped_reg <= 1'b0;
    end
    else
    begin
      data_reg <= data_next;
      skipped_reg <= skipped_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign req_ready = in_idle;
  assign mem_req_valid = in_issue;
  assign mem_req_write = write_reg;
  assign mem_req_addr = addr_reg;
  assign mem_req_byte_en = be_reg;
  assign mem_req_wdata = wdata_reg;
  // The hint only steers cache placement; data handling is the same
  assign mem_req_last_hint = hint_reg;
  assign done_valid = in_done;
  assign done_is_load = is_load_reg;
  assign done_mem_skipped = skipped_reg;
  assign done_dest_vreg = dest_reg;
  assign done_data = data_reg;

endmodule // vlsl_top

`default_nettype wire

/* vlsl_cfg.svh */
`ifndef VLSL_CFG_SVH
`define VLSL_CFG_SVH

// ----------------------------------------
// Lane geometry
// ----------------------------------------
`define VLSL_LANES 5'h10
`define VLSL_ALL_LANES 16'hffff
`define VLSL_NO_LANES 16'h0000
`define VLSL_ZERO_QW 128'h0
`define VLSL_ZERO_EA 64'h0
`define VLSL_ZERO_OFF 4'h0

// ----------------------------------------
// Effective address alignment masks
// ----------------------------------------
`define VLSL_ALIGN_QW 64'hffff_ffff_ffff_fff0
`define VLSL_ALIGN_WD 64'hffff_ffff_ffff_fffc
`define VLSL_ALIGN_HW 64'hffff_ffff_ffff_fffe
`define VLSL_ALIGN_BYTE 64'hffff_ffff_ffff_ffff

// ----------------------------------------
// Element sizes in lanes
// ----------------------------------------
`define VLSL_SIZE_BYTE 5'h01
`define VLSL_SIZE_HALF 5'h02
`define VLSL_SIZE_WORD 5'h04

`endif

/* vlsl_pkg.sv */
`default_nettype none
package vlsl_pkg;

  // ----------------------------------------
  // Operation codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    OP_LOAD_QUAD = 4'h0,
    OP_LOAD_LEFT = 4'h1,
    OP_LOAD_RIGHT = 4'h2,
    OP_LOAD_ELEM_BYTE = 4'h3,
    OP_LOAD_ELEM_HALF = 4'h4,
    OP_LOAD_ELEM_WORD = 4'h5,
    OP_MAKE_LEFT_SHIFT_CONTROL = 4'h6,
    OP_MAKE_RIGHT_SHIFT_CONTROL = 4'h7,
    OP_STORE_QUAD = 4'h8,
    OP_STORE_LEFT = 4'h9,
    OP_STORE_RIGHT = 4'ha,
    OP_STORE_ELEM_BYTE = 4'hb,
    OP_STORE_ELEM_HALF = 4'hc,
    OP_STORE_ELEM_WORD = 4'hd
  } vlsl_op_type;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PREP = 5'h02,
    ST_ISSUE = 5'h04,
    ST_WAIT = 5'h08,
    ST_DONE = 5'h10
  } vlsl_state_type;

endpackage

`default_nettype wire

/* vlsl_steer_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface vlsl_steer_if;
  import vlsl_pkg::*;
  vlsl_op_type op;
  logic [3:0] lane_offset;
  logic [127:0] source_vreg;
  logic [127:0] mem_rdata;
  logic [127:0] load_data;
  logic [127:0] store_data;
  logic [15:0] byte_en;

  modport user (
    output op,
    output lane_offset,
    output source_vreg,
    output mem_rdata,
    input load_data,
    input store_data,
    input byte_en
  );

  modport steer (
    input op,
    input lane_offset,
    input source_vreg,
    input mem_rdata,
    output load_data,
    output store_data,
    output byte_en
  );
endinterface

`default_nettype wire

/* vlsl_lane_steer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "vlsl_cfg.svh"

module vlsl_lane_steer
  import vlsl_pkg::*;
(
  vlsl_steer_if.steer st
);

  // ----------------------------------------
  // Lane run decoding
  // ----------------------------------------
  // Enable bit i covers data bits 8i+7:8i, which is lane 15-i
  function automatic logic [15:0] lane_run(input logic [4:0] first, input logic [4:0] count);
    logic [15:0] m;
    logic [4:0] lane;
    m = `VLSL_NO_LANES;
    for (int i = 0; i < 16; i++)
    begin
      lane = 5'(15 - i);
      m[i] = (lane >= first) && (lane < 5'(first + count));
    end
    return m;
  endfunction

  wire [4:0] off5 = {1'b0, st.lane_offset};
  wire [4:0] right_lanes = 5'(`VLSL_LANES - off5);
  wire [6:0] left_bits = {st.lane_offset, 3'h0};
  wire [7:0] right_bits = {right_lanes, 3'h0};
  wire is_right_ctl = (st.op == OP_MAKE_RIGHT_SHIFT_CONTROL);
  wire [4:0] ctl_start = is_right_ctl ? right_lanes : off5;

  // ----------------------------------------
  // Shift control vector
  // ----------------------------------------
  logic [127:0] ctl_data;
  genvar k;
  generate
    for (k = 0; k < 16; k++)
    begin : g_ctl
      assign ctl_data[127 - 8 * k -: 8] = {3'h0, 5'(ctl_start + 5'(k))};
    end
  endgenerate

  // ----------------------------------------
  // Data steering
  // ----------------------------------------
  wire [127:0] left_load = st.mem_rdata << left_bits;
  wire [127:0] right_load = (st.lane_offset == `VLSL_ZERO_OFF) ? `VLSL_ZERO_QW : st.mem_rdata >> right_bits;
  wire [127:0] left_store = st.source_vreg >> left_bits;
  wire [127:0] right_store = st.source_vreg << right_bits;

  assign st.load_data = (st.op == OP_LOAD_LEFT) ? left_load :
                        (st.op == OP_LOAD_RIGHT) ? right_load :
                        (st.op == OP_MAKE_LEFT_SHIFT_CONTROL || is_right_ctl) ? ctl_data :
                        st.mem_rdata;

  assign st.store_data = (st.op == OP_STORE_LEFT) ? left_store :
                         (st.op == OP_STORE_RIGHT) ? right_store :
                         st.source_vreg;

  // Only the addressed bytes are enabled so the rest of the quadword survives
  assign st.byte_en = (st.op == OP_STORE_LEFT) ? lane_run(off5, right_lanes) :
                      (st.op == OP_STORE_RIGHT) ? lane_run(5'h00, off5) :
                      (st.op == OP_STORE_ELEM_BYTE) ? lane_run(off5, `VLSL_SIZE_BYTE) :
                      (st.op == OP_STORE_ELEM_HALF) ? lane_run(off5, `VLSL_SIZE_HALF) :
                      (st.op == OP_STORE_ELEM_WORD) ? lane_run(off5, `VLSL_SIZE_WORD) :
                      `VLSL_ALL_LANES;

endmodule // vlsl_lane_steer

`default_nettype wire

/* vlsl_mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ------
// Memory side model
// ------
module vlsl_mem_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire logic mem_req_write,
  input wire logic [63:0] mem_req_addr,
  output logic mem_rsp_valid,
  output logic [127:0] mem_rsp_rdata
);
  logic tick_reg;
  logic pend_reg;
  logic [1:0] wait_reg;
  logic [127:0] q_reg;
  function automatic logic [127:0] pat(input logic [63:0] a);
    for (int j = 0; j < 16; j++)
      pat[8*j +: 8] = {a[7:4], 4'(j)} ^ 8'ha5;
  endfunction
  // Slow mode accepts only every other cycle
  assign mem_req_ready = !slow || tick_reg;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_reg <= 1'b0;
      pend_reg <= 1'b0;
      wait_reg <= 2'h0;
      q_reg <= 128'h0;
      mem_rsp_valid <= 1'b0;
      mem_rsp_rdata <= 128'h0;
    end
    else
    begin
      tick_reg <= !tick_reg;
      mem_rsp_valid <= 1'b0;
      // Data lines never hold a stale value between answers
      mem_rsp_rdata <= ~mem_rsp_rdata;
      if (mem_req_valid && mem_req_ready && !mem_req_write)
      begin
        pend_reg <= 1'b1;
        q_reg <= pat(mem_req_addr);
        wait_reg <= slow ? 2'h3 : 2'h0;
      end
      else if (pend_reg && wait_reg == 2'h0)
      begin
        pend_reg <= 1'b0;
        mem_rsp_valid <= 1'b1;
        mem_rsp_rdata <= q_reg;
      end
      else if (pend_reg)
        wait_reg <= wait_reg - 2'h1;
    end
  end
endmodule // vlsl_mem_model
`default_nettype wire

/* vlsl_top_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ------
// Port checks
// ------
module vlsl_top_assertions
  import vlsl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire vlsl_op_type req_op,
  input wire logic req_last_hint,
  input wire logic req_base_is_zero,
  input wire logic [63:0] req_base_gpr,
  input wire logic [63:0] req_index_gpr,
  input wire logic mem_req_valid,
  input wire logic mem_req_ready,
  input wire logic mem_req_write,
  input wire logic [63:0] mem_req_addr,
  input wire logic [15:0] mem_req_byte_en,
  input wire logic [127:0] mem_req_wdata,
  input wire logic mem_req_last_hint,
  input wire logic mem_rsp_valid,
  input wire logic done_valid,
  input wire logic done_is_load,
  input wire logic done_mem_skipped,
  input wire logic [127:0] done_data
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic take;
  logic [63:0] ea;
  logic [63:0] ea_reg;
  logic hint_reg;
  assign take = req_valid && req_ready;
  assign ea = (req_base_is_zero ? 64'h0 : req_base_gpr) + req_index_gpr;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ea_reg <= 64'h0;
      hint_reg <= 1'b0;
    end
    else if (take)
    begin
      ea_reg <= ea;
      hint_reg <= req_last_hint;
    end
  end
  a_busy_after_take: assert property (take |=> !req_ready)
    else $error("ready high while busy");
  a_ready_after_done: assert property (done_valid |=> req_ready)
    else $error("ready low after done");
  a_addr_from_sum: assert property (mem_req_valid |-> mem_req_addr == {ea_reg[63:4], 4'h0})
    else $error("memory address wrong");
  a_load_all_bytes: assert property (mem_req_valid && !mem_req_write |-> mem_req_byte_en == 16'hffff)
    else $error("load byte enables wrong");
  a_req_held: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req_addr)
    && $stable(mem_req_byte_en) && $stable(mem_req_wdata))
    else $error("memory request changed while waiting");
  a_hint_passed: assert property (mem_req_valid |-> mem_req_last_hint == hint_reg)
    else $error("hint not passed");
  a_ctrl_latency: assert property (take && (req_op == OP_MAKE_LEFT_SHIFT_CONTROL
    || req_op == OP_MAKE_RIGHT_SHIFT_CONTROL) |=> !mem_req_valid ##1 done_valid)
    else $error("control op timing wrong");
  a_aligned_skip: assert property (take && (req_op == OP_LOAD_RIGHT || req_op == OP_STORE_RIGHT)
    && ea[3:0] == 4'h0 |=> !mem_req_valid ##1 (done_valid && done_mem_skipped))
    else $error("aligned right op touched memory");
  a_store_done: assert property (mem_req_valid && mem_req_ready && mem_req_write
    |=> done_valid && !done_is_load && done_data == 128'h0)
    else $error("store completion wrong");
  a_load_done: assert property (mem_rsp_valid |=> done_valid && done_is_load)
    else $error("load completion missing");
endmodule // vlsl_top_assertions
bind vlsl_top vlsl_top_assertions u_chk (.*);
`default_nettype wire

/* vlsl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb
  import vlsl_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready;
  vlsl_op_type req_op = OP_LOAD_QUAD;
  logic req_last_hint = 1'b0;
  logic req_base_is_zero = 1'b0;
  logic [63:0] req_base_gpr = 64'h0;
  logic [63:0] req_index_gpr = 64'h0;
  logic [127:0] req_source_vreg = 128'h0;
  logic [4:0] req_dest_vreg = 5'h3;
  logic mem_req_valid, mem_req_ready, mem_req_write, mem_req_last_hint, mem_rsp_valid;
  logic [63:0] mem_req_addr, got_addr;
  logic [15:0] mem_req_byte_en, got_be, be_e;
  logic [127:0] mem_req_wdata, mem_rsp_rdata, done_data, got_wd, got_data, m;
  logic done_valid, done_is_load, done_mem_skipped, got_seen, got_skip, got_hint, got_wr;
  logic [4:0] done_dest_vreg;
  int checks = 0;
  int bad_count = 0;
  // Store data with a distinct value in every lane
  localparam logic [127:0] SRC = 128'h00112233_44556677_8899aabb_ccddeeff;
  always #4 sys_clk = ~sys_clk;
  vlsl_top uut (.*);
  vlsl_mem_model u_mem (.*);
  function automatic logic [127:0] exp_quad(input logic [63:0] a);
    for (int j = 0; j < 16; j++)
      exp_quad[8*j +: 8] = {a[7:4], 4'(j)} ^ 8'ha5;
  endfunction
  // ------
  // Shared tasks
  // ------
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Samples at the falling edge so design updates have landed
  task automatic run(input vlsl_op_type o, input logic h, input logic z, input logic [63:0] b,
    input logic [63:0] x);
    int n;
    n = 0;
    got_seen = 1'b0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_op <= o;
    req_last_hint <= h;
    req_base_is_zero <= z;
    req_base_gpr <= b;
    req_index_gpr <= x;
    req_source_vreg <= SRC;
    req_dest_vreg <= 5'(o) ^ 5'h15;
    @(negedge sys_clk);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    while (n < 60)
    begin
      @(negedge sys_clk);
      n++;
      if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1)
      begin
        got_seen = 1'b1;
        got_addr = mem_req_addr;
        got_be = mem_req_byte_en;
        got_wd = mem_req_wdata;
        got_hint = mem_req_last_hint;
        got_wr = mem_req_write;
      end
      if (done_valid === 1'b1)
        break;
    end
    chk(done_valid, 1'b1);
    got_data = done_data;
    got_skip = done_mem_skipped;
    chk(done_dest_vreg, 5'(o) ^ 5'h15);
    chk(done_is_load, !o[3]);
    if (got_seen)
      chk(got_wr, o[3]);
    @(posedge sys_clk);
  endtask
  // ------
  // Scenarios
  // ------
  task automatic t_quad();
    logic [63:0] e;
    for (int h = 0; h < 2; h++)
    begin
      e = h ? 64'h10 : 64'h1000_0000_0000_0010;
      run(OP_LOAD_QUAD, h[0], h[0], 64'h0fff_ffff_ffff_fff8, 64'h1b);
      chk(got_addr, e);
      chk(got_data, exp_quad(e));
      chk(got_hint, h[0]);
      run(OP_STORE_QUAD, h[0], 1'b1, 64'h5, 64'h27);
      chk(got_addr, 64'h20);
      chk(got_wd, SRC);
      chk(got_be, 16'hffff);
    end
  endtask
  task automatic t_loads();
    int a;
    for (int off = 0; off < 16; off++)
    begin
      slow <= off[0];
      run(OP_LOAD_LEFT, 1'b0, 1'b1, 64'h0, 64'h40 + off);
      chk(got_data, exp_quad(64'h40) << (8 * off));
      run(OP_LOAD_RIGHT, off[1], 1'b1, 64'h0, 64'h40 + off);
      chk(got_data, exp_quad(64'h40) >> (8 * (16 - off)));
      chk({got_seen, got_skip}, {off != 0, off == 0});
      for (int k = 0; k < 3; k++)
      begin
        a = off - off % (1 << k);
        m = ({128{1'b1}} << (128 - 8 * (1 << k))) >> (8 * a);
        run(vlsl_op_type'(4'h3 + k), 1'b0, 1'b1, 64'h0, 64'h40 + off);
        chk(got_data & m, exp_quad(64'h40) & m);
      end
    end
  endtask
  task automatic t_ctrl();
    logic [127:0] el, er;
    for (int off = 0; off < 16; off++)
    begin
      for (int k = 0; k < 16; k++)
      begin
        el[127 - 8 * k -: 8] = 8'(off + k);
        er[127 - 8 * k -: 8] = 8'(16 - off + k);
      end
      run(OP_MAKE_LEFT_SHIFT_CONTROL, 1'b0, 1'b0, 64'h300, 64'h10 + off);
      chk(got_data, el);
      run(OP_MAKE_RIGHT_SHIFT_CONTROL, 1'b0, 1'b0, 64'h300, 64'h10 + off);
      chk(got_data, er);
    end
  endtask
  task automatic t_stores();
    int a;
    for (int off = 0; off < 16; off++)
    begin
      slow <= off[1];
      run(OP_STORE_LEFT, 1'b0, 1'b1, 64'h0, 64'h80 + off);
      be_e = 16'hffff >> off;
      m = {128{1'b1}} >> (8 * off);
      chk(got_be, be_e);
      chk(got_wd & m, SRC >> (8 * off));
      run(OP_STORE_RIGHT, 1'b1, 1'b1, 64'h0, 64'h80 + off);
      chk(got_seen, off != 0);
      if (off != 0)
      begin
        be_e = 16'hffff << (16 - off);
        m = ~({128{1'b1}} >> (8 * off));
        chk(got_be, be_e);
        chk(got_wd & m, SRC << (8 * (16 - off)));
      end
      for (int k = 0; k < 3; k++)
      begin
        a = off - off % (1 << k);
        be_e = 16'hffff << (16 - (1 << k));
        be_e = be_e >> a;
        m = ({128{1'b1}} << (128 - 8 * (1 << k))) >> (8 * a);
        run(vlsl_op_type'(4'hb + k), 1'b0, 1'b1, 64'h0, 64'h80 + off);
        chk(got_addr, 64'h80);
        chk(got_be, be_e);
        chk(got_wd & m, SRC & m);
      end
    end
  endtask
  initial
  begin
    #100000;
    bad_count++;
    summarize();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_quad();
    t_loads();
    t_ctrl();
    t_stores();
    summarize();
  end
endmodule // tb
`default_nettype wire
